// >>> sbc_flag_cfg.svh
// constants for the flag and status readout block
// assumes it is included by bare name from the package, the readout module and the testbench
`ifndef SBC_FLAG_CFG_SVH
`define SBC_FLAG_CFG_SVH

// ----------------------------------------------------------------
// frame and command layout
// ----------------------------------------------------------------
`define SBC_FRAME_BITS 5'h10
`define SBC_FRAME_OVER 5'h11
`define SBC_HDR_BITS 5'h08
`define SBC_CMD_BANK_HI 15
`define SBC_CMD_BANK_LO 14
`define SBC_CMD_ADDR_HI 13
`define SBC_CMD_ADDR_LO 9
`define SBC_CMD_READ_BIT 8
`define SBC_CMD_HALF_BIT 7

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SBC_ADDR_CAN 5'h10
`define SBC_ADDR_IO 5'h11
`define SBC_ADDR_SAFE 5'h12
`define SBC_ADDR_LIN 5'h13

// ----------------------------------------------------------------
// identification defaults, values arbitrary
// ----------------------------------------------------------------
`define SBC_ID_REG_5V0 1'h1
`define SBC_ID_PART 2'h1
`define SBC_ID_CODE 5'h0a

// ----------------------------------------------------------------
// synchroniser width and reset values
// ----------------------------------------------------------------
`define SBC_SYNC_W 62
`define SBC_BYTE_ZERO 8'h00

`endif

// >>> sbc_flag_pkg.sv
// types shared by the flag and status readout block
// assumes sbc_flag_cfg.svh is on the include path
`include "sbc_flag_cfg.svh"

package sbc_flag_pkg;

  // ----------------------------------------------------------------
  // bank select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    bank_live = 2'b00,
    bank_fail = 2'b11
  } bank_t;

  // ----------------------------------------------------------------
  // whole state of the readout block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk_q;
    logic [4:0] count;
    logic [15:0] cmd;
    logic [7:0] resp;
    logic [7:0] out;
    logic miso;
    logic miso_oe;
    logic [7:0] can_f;
    logic [7:0] can_s;
    logic [7:0] io_f;
    logic [7:0] io_w;
    logic [7:0] safe_f;
    logic [7:0] safe_r;
    logic [7:0] lin_f;
  } state_t;

endpackage

// >>> sbc_flag_status_readout.sv
// flag and status readout bank behind a serial read command
// assumes a host spi master, mode with mosi moving on sclk fall and miso moving on sclk rise
`timescale 1ns/1ps
`default_nettype none
`include "sbc_flag_cfg.svh"

module sbc_flag_status_readout #(
  parameter logic id_reg_5v0 = `SBC_ID_REG_5V0,
  parameter logic [1:0] id_part = `SBC_ID_PART,
  parameter logic [4:0] id_code = `SBC_ID_CODE
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // failure conditions
  input wire logic [6:0] can_fail_cond,
  input wire logic [7:0] can_short_cond,
  input wire logic [7:0] io_fail_cond,
  input wire logic [7:0] io_wake_cond,
  input wire logic [6:0] safe_fail_cond,
  input wire logic [4:0] safety_reset_cond,
  input wire logic [6:0] lin_fail_cond,
  // live state
  input wire logic can_driver_on,
  input wire logic can_receiver_on,
  input wire logic transceiver_wake_enable,
  input wire logic [3:0] io_level,
  input wire logic lin_live_on,
  input wire logic lin_wake_enable
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`SBC_SYNC_W-1:0] s;
  logic sclk_s, cs_n_s, cs_act_s, mosi_s;
  logic [6:0] can_fc, safe_fc, lin_fc;
  logic [7:0] can_sc, io_fc, io_wc;
  logic [4:0] safe_rc;
  logic drv_s, rcv_s, cwk_s, lin_s, lwk_s;
  logic [3:0] lvl_s;

  sbc_sync2 #(.W(`SBC_SYNC_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({sclk, ~cs_n, mosi, can_fail_cond, can_short_cond, io_fail_cond, io_wake_cond,
          safe_fail_cond, safety_reset_cond, lin_fail_cond, can_driver_on, can_receiver_on,
          transceiver_wake_enable, io_level, lin_live_on, lin_wake_enable}),
    .dout(s)
  );

  assign {sclk_s, cs_act_s, mosi_s, can_fc, can_sc, io_fc, io_wc, safe_fc, safe_rc, lin_fc,
          drv_s, rcv_s, cwk_s, lvl_s, lin_s, lwk_s} = s;
  // select travels active high so the cleared flops read as deselected, no false frame
  assign cs_n_s = ~cs_act_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // new condition wins over the read that clears, so no event is lost
  function automatic logic [7:0] latch_upd(input logic [7:0] flag, input logic [7:0] cond,
                                           input logic [7:0] hit);
    latch_upd = cond | (flag & ~hit);
  endfunction

  function automatic logic [7:0] hit_mask(input logic en, input logic [15:0] c,
                                          input logic [4:0] a, input logic h,
                                          input logic [7:0] r);
    if (en && c[`SBC_CMD_ADDR_HI:`SBC_CMD_ADDR_LO] == a && c[`SBC_CMD_HALF_BIT] == h) begin
      hit_mask = r;
    end else begin
      hit_mask = `SBC_BYTE_ZERO;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sbc_flag_pkg::state_t st, next_st;
  logic [15:0] hdr;
  logic [7:0] pick;
  logic load_now, clear_now, rise;

  assign hdr = {st.cmd[14:0], mosi_s};
  assign rise = sclk_s & ~st.sclk_q;

  always_comb begin
    pick = `SBC_BYTE_ZERO;
    unique case (hdr[`SBC_CMD_ADDR_HI-7:`SBC_CMD_ADDR_LO-7] | 5'h00)
      default: pick = `SBC_BYTE_ZERO;
    endcase
    if (hdr[`SBC_CMD_BANK_HI-7:`SBC_CMD_BANK_LO-7] == sbc_flag_pkg::bank_fail) begin
      unique case (hdr[`SBC_CMD_ADDR_HI-7:`SBC_CMD_ADDR_LO-7])
        `SBC_ADDR_CAN: pick = hdr[0] ? st.can_s : st.can_f;
        `SBC_ADDR_IO: pick = hdr[0] ? st.io_w : st.io_f;
        `SBC_ADDR_SAFE: pick = hdr[0] ? st.safe_r : st.safe_f;
        `SBC_ADDR_LIN: pick = hdr[0] ? `SBC_BYTE_ZERO : st.lin_f;
        default: pick = `SBC_BYTE_ZERO;
      endcase
    end else if (hdr[`SBC_CMD_BANK_HI-7:`SBC_CMD_BANK_LO-7] == sbc_flag_pkg::bank_live) begin
      unique case (hdr[`SBC_CMD_ADDR_HI-7:`SBC_CMD_ADDR_LO-7])
        `SBC_ADDR_CAN: pick = {drv_s, rcv_s, cwk_s, 5'h00};
        `SBC_ADDR_IO: pick = {1'b0, lvl_s[3], 1'b0, lvl_s[2], 1'b0, lvl_s[1], 1'b0, lvl_s[0]};
        `SBC_ADDR_SAFE: pick = {id_reg_5v0, id_part, id_code};
        `SBC_ADDR_LIN: pick = {lin_s, lwk_s, 6'h00};
        default: pick = `SBC_BYTE_ZERO;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    load_now = 1'b0;
    clear_now = 1'b0;
    next_st.sclk_q = sclk_s;
    if (cs_n_s) begin
      next_st.count = 5'h00;
      next_st.miso = 1'b0;
      next_st.miso_oe = 1'b0;
      // only a whole, well formed failure read may clear
      clear_now = st.miso_oe && st.count == `SBC_FRAME_BITS &&
                  st.cmd[`SBC_CMD_BANK_HI:`SBC_CMD_BANK_LO] == sbc_flag_pkg::bank_fail &&
                  st.cmd[`SBC_CMD_READ_BIT];
    end else begin
      next_st.miso_oe = 1'b1;
      if (rise && st.count != `SBC_FRAME_OVER) begin
        next_st.count = st.count + 5'h01;
        if (st.count != `SBC_FRAME_BITS) begin
          next_st.cmd = hdr;
        end
        if (st.count == `SBC_HDR_BITS) begin
          load_now = 1'b1;
          next_st.resp = pick;
          next_st.miso = pick[7];
          next_st.out = {pick[6:0], 1'b0};
        end else if (st.count > `SBC_HDR_BITS && st.count < `SBC_FRAME_BITS) begin
          next_st.miso = st.out[7];
          next_st.out = {st.out[6:0], 1'b0};
        end
      end
    end
    // flag latches, set wins over clear
    next_st.can_f = latch_upd(st.can_f, {can_fc[6], 1'b0, can_fc[5:0]},
                              hit_mask(clear_now, st.cmd, `SBC_ADDR_CAN, 1'b0, st.resp));
    next_st.can_s = latch_upd(st.can_s, can_sc,
                              hit_mask(clear_now, st.cmd, `SBC_ADDR_CAN, 1'b1, st.resp));
    next_st.io_f = latch_upd(st.io_f, io_fc,
                             hit_mask(clear_now, st.cmd, `SBC_ADDR_IO, 1'b0, st.resp));
    next_st.io_w = latch_upd(st.io_w, io_wc,
                             hit_mask(clear_now, st.cmd, `SBC_ADDR_IO, 1'b1, st.resp));
    next_st.safe_f = latch_upd(st.safe_f, {safe_fc, 1'b0},
                               hit_mask(clear_now, st.cmd, `SBC_ADDR_SAFE, 1'b0, st.resp));
    next_st.safe_r = latch_upd(st.safe_r, {3'h0, safe_rc},
                               hit_mask(clear_now, st.cmd, `SBC_ADDR_SAFE, 1'b1, st.resp));
    next_st.lin_f = latch_upd(st.lin_f, {1'b0, lin_fc},
                              hit_mask(clear_now, st.cmd, `SBC_ADDR_LIN, 1'b0, st.resp));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign miso = st.miso;
  assign miso_oe = st.miso_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_can_oc_latch: assert property (@(posedge clk) disable iff (sys_rst)
    can_fc[0] |=> st.can_f[0]) else $error("can overcurrent not latched");
  a_flag_holds: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(st.safe_r[0]) |-> $past(clear_now) && !$past(safe_rc[0]))
    else $error("safety flag dropped without a read");
  a_bank_unused: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8] != hdr[7] |=> st.resp == `SBC_BYTE_ZERO)
    else $error("undefined bank gave data");
  a_can_fail_gap: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:1] == {2'b11, `SBC_ADDR_CAN, 1'b1} && !hdr[0] |=> st.resp[6] == 1'b0)
    else $error("unused can flag bit set");
  a_can_short_rd: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:1] == {2'b11, `SBC_ADDR_CAN, 1'b1} && hdr[0] |=> st.resp == $past(st.can_s))
    else $error("can short byte wrong");
  a_can_live_rd: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:1] == {2'b00, `SBC_ADDR_CAN, 1'b1} |=> st.miso == $past(drv_s) ##1
    st.resp[4:0] == 5'h00) else $error("can live byte wrong");
  a_lin_live_rd: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:1] == {2'b00, `SBC_ADDR_LIN, 1'b1} |=>
    st.resp == {$past(lin_s), $past(lwk_s), 6'h00}) else $error("lin live byte wrong");
  a_ident_rd: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:1] == {2'b00, `SBC_ADDR_SAFE, 1'b1} |=>
    st.resp == {id_reg_5v0, id_part, id_code}) else $error("identification byte wrong");
  a_safe_rst_rd: assert property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:1] == {2'b11, `SBC_ADDR_SAFE, 1'b1} && hdr[0] |=>
    st.resp[7:5] == 3'h0 && st.resp[4:0] == $past(st.safe_r[4:0]))
    else $error("safety reset byte wrong");
  a_clear_wellformed: assert property (@(posedge clk) disable iff (sys_rst)
    clear_now |-> st.cmd[`SBC_CMD_READ_BIT] && st.count == `SBC_FRAME_BITS)
    else $error("clear without a proper read");

  c_fail_clear: cover property (@(posedge clk) disable iff (sys_rst) clear_now && st.resp != 8'h00);
  c_live_read: cover property (@(posedge clk) disable iff (sys_rst)
    load_now && hdr[8:7] == 2'b00);
  c_set_vs_clear: cover property (@(posedge clk) disable iff (sys_rst)
    clear_now && can_fc[0] && st.can_f[0]);

endmodule

`default_nettype wire

// >>> sbc_host_model.sv
// host master model driving read frames into the flag readout block
// assumes it shares clk with the device; the bench calls xfer
`timescale 1ns/1ps
`default_nettype none

module sbc_host_model (
  // clock
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // ----------------------------------------------------------------
  // frame engine, 4 clk per half period of sclk
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic half_wait();
    repeat (4) @(posedge clk);
  endtask

  // miso is taken just before the next rise, where it has long settled
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [7:0] resp);
    resp = 8'h00;
    cs_n <= 1'b0;
    half_wait();
    for (int i = 0; i < nbits; i++) begin
      mosi <= (i < 16) ? cmd[15 - i] : 1'b0;
      half_wait();
      if (i >= 9) resp = {resp[6:0], miso};
      sclk <= 1'b1;
      half_wait();
      sclk <= 1'b0;
    end
    half_wait();
    resp = {resp[6:0], miso};
    cs_n <= 1'b1;
    mosi <= ~mosi; // released line never shows the stale bit
    repeat (6) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// >>> sbc_sync2.sv
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a level that may change at any time
`timescale 1ns/1ps
`default_nettype none

module sbc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // the first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> testbench.sv
// self-checking bench for the flag and status readout block
// assumes sbc_flag_cfg.svh on the include path and the host model beside it
`timescale 1ns/1ps
`default_nettype none
`include "sbc_flag_cfg.svh"

module testbench;
  logic clk, sys_rst, sclk, cs_n, mosi, miso, miso_oe;
  logic [6:0] can_fail_cond, safe_fail_cond, lin_fail_cond;
  logic [7:0] can_short_cond, io_fail_cond, io_wake_cond, got;
  logic [4:0] safety_reset_cond;
  logic [3:0] io_level;
  logic can_driver_on, can_receiver_on, transceiver_wake_enable, lin_live_on, lin_wake_enable;
  int num_errors, n_compared;
  localparam logic [1:0] fb = sbc_flag_pkg::bank_fail;
  localparam logic [1:0] lb = sbc_flag_pkg::bank_live;

  sbc_flag_status_readout #(.id_reg_5v0(1'h0), .id_part(2'h2), .id_code(5'h13)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .can_fail_cond(can_fail_cond), .can_short_cond(can_short_cond),
    .io_fail_cond(io_fail_cond), .io_wake_cond(io_wake_cond), .safe_fail_cond(safe_fail_cond),
    .safety_reset_cond(safety_reset_cond), .lin_fail_cond(lin_fail_cond),
    .can_driver_on(can_driver_on), .can_receiver_on(can_receiver_on),
    .transceiver_wake_enable(transceiver_wake_enable), .io_level(io_level),
    .lin_live_on(lin_live_on), .lin_wake_enable(lin_wake_enable));

  sbc_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic rd(input logic [1:0] bank, input logic [4:0] addr, input logic half,
                    input int n = 16);
    i_host.xfer({bank, addr, 1'b1, half, 7'h00}, n, got);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (3) begin
      @(negedge clk);
      chk8({6'h00, miso_oe, miso}, 8'h00, "idle after reset");
    end
    repeat (2) @(posedge clk);
    fork
      rd(fb, `SBC_ADDR_CAN, 1'b0);
      begin
        repeat (10) @(negedge clk);
        chk8({7'h00, miso_oe}, 8'h01, "driving in frame");
      end
    join
    chk8(got, 8'h00, "flags clear after reset");
    $display("test reset done");
  endtask

  // all flag banks: set, hold while cause stays, keep after cause goes, clear on read
  task automatic t_flags();
    logic [5:0] sel [7] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26};
    logic [7:0] exp [7] = '{8'h9a, 8'ha5, 8'h3c, 8'hc3, 8'haa, 8'h15, 8'h2b};
    {can_fail_cond, can_short_cond, io_fail_cond, io_wake_cond} <= {7'h5a, 8'ha5, 8'h3c, 8'hc3};
    {safe_fail_cond, safety_reset_cond, lin_fail_cond} <= {7'h55, 5'h15, 7'h2b};
    repeat (4) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      if (p == 2) begin
        {can_fail_cond, can_short_cond, io_fail_cond, io_wake_cond} <= '0;
        {safe_fail_cond, safety_reset_cond, lin_fail_cond} <= '0;
      end
      for (int k = 0; k < 7; k++) begin
        rd(fb, sel[k][5:1], sel[k][0]);
        chk8(got, (p == 3) ? 8'h00 : exp[k], "flag read");
      end
    end
    $display("test flags done");
  endtask

  task automatic live_round(input logic [7:0] e_can, input logic [7:0] e_io,
                            input logic [7:0] e_lin);
    repeat (4) @(posedge clk);
    rd(lb, `SBC_ADDR_CAN, 1'b1);
    chk8(got, e_can, "live can");
    rd(lb, `SBC_ADDR_IO, 1'b1);
    chk8(got, e_io, "live io");
    rd(lb, `SBC_ADDR_SAFE, 1'b1);
    chk8(got, 8'h53, "identification");
    rd(lb, `SBC_ADDR_LIN, 1'b1);
    chk8(got, e_lin, "live lin");
  endtask

  task automatic t_live();
    {can_driver_on, can_receiver_on, transceiver_wake_enable} <= 3'h5;
    {io_level, lin_live_on, lin_wake_enable} <= {4'hb, 2'h1};
    live_round(8'ha0, 8'h45, 8'h40);
    {can_driver_on, can_receiver_on, transceiver_wake_enable} <= 3'h2;
    {io_level, lin_live_on, lin_wake_enable} <= {4'h4, 2'h2};
    live_round(8'h40, 8'h10, 8'h80);
    $display("test live done");
  endtask

  // refused banks and lin half high answer zero; neither they, a live read, a short nor a long frame clears
  task automatic t_refuse();
    can_fail_cond <= 7'h01;
    repeat (4) @(posedge clk);
    can_fail_cond <= 7'h00;
    repeat (4) @(posedge clk);
    rd(2'b01, `SBC_ADDR_CAN, 1'b0);
    chk8(got, 8'h00, "bank 01");
    rd(2'b10, `SBC_ADDR_CAN, 1'b0);
    chk8(got, 8'h00, "bank 10");
    rd(fb, `SBC_ADDR_LIN, 1'b1);
    chk8(got, 8'h00, "lin half high");
    rd(lb, `SBC_ADDR_CAN, 1'b0);
    chk8(got, 8'h40, "live can half low");
    rd(fb, `SBC_ADDR_CAN, 1'b0, 12);
    rd(fb, `SBC_ADDR_CAN, 1'b0, 17);
    rd(fb, `SBC_ADDR_CAN, 1'b0);
    chk8(got, 8'h01, "flag kept");
    rd(fb, `SBC_ADDR_CAN, 1'b0);
    chk8(got, 8'h00, "flag cleared");
    $display("test refuse done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {can_fail_cond, can_short_cond, io_fail_cond, io_wake_cond} = '0;
    {safe_fail_cond, safety_reset_cond, lin_fail_cond, io_level} = '0;
    {can_driver_on, can_receiver_on, transceiver_wake_enable} = '0;
    {lin_live_on, lin_wake_enable} = '0;
    num_errors = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_flags();
    t_live();
    t_refuse();
    final_report();
  end

  // about 6.4k clk of frames expected; over six times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule

`default_nettype wire
